// ===== gppc_defs.svh
// Constants for the port pin configuration logic
`ifndef GPPC_DEFS_SVH
`define GPPC_DEFS_SVH
`define GPPC_OFF_DATA 4'h0
`define GPPC_OFF_CFG_A 4'h1
`define GPPC_OFF_CFG_B 4'h2
`define GPPC_OFF_CFG_C 4'h3
`define GPPC_OFF_STATUS 4'h4
`define GPPC_OFF_PIN 4'h5
`define GPPC_OFF_AFOUT 4'h6
`define GPPC_RST_DATA 8'hff
`define GPPC_RST_CFG_A 8'h00
`define GPPC_RST_CFG_B 8'h00
`define GPPC_RST_CFG_C 8'h00
`define GPPC_RST_CFG_C_NOPU 8'hff
`define GPPC_STAT_PHASE 0
`define GPPC_STAT_HOLD 1
`define GPPC_INSTR_CYCLES 4'h4
`endif

// ===== gppc_pkg.sv
// Types for the port pin configuration logic
package gppc_pkg;
   typedef enum logic [2:0] {
      GPPC_BID_WP = 3'b000,
      GPPC_BID_OD = 3'b100,
      GPPC_OUT_PP = 3'b010,
      GPPC_OUT_OD = 3'b110,
      GPPC_IN_CMOS = 3'b001,
      GPPC_IN_TTL = 3'b101,
      GPPC_AF_PP = 3'b011,
      GPPC_AF_OD = 3'b111
   } gppc_cfg_t;
   typedef enum logic [1:0] {
      GPPC_ST_START = 2'b00,
      GPPC_ST_EXEC = 2'b01,
      GPPC_ST_END = 2'b11
   } gppc_phase_t;
endpackage

// ===== gppc_bit.sv
// One port bit: latches, buffer drive and alternate function routing
`timescale 1ns/100ps
module gppc_bit #(
   parameter int AF_COUNT = 2,
   parameter bit PULLUP_PRESENT = 1'b1,
   parameter bit ADC_BIT = 1'b0
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [2:0] cfg,
   input wire logic sample_start,
   input wire logic xfer_end,
   input wire logic wr_data,
   input wire logic wr_bit,
   input wire logic [AF_COUNT-1:0] altfunc_output_cfg,
   input wire logic [AF_COUNT-1:0] altfunc_output_cfg_en,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic weak_pullup_en,
   output logic input_latch,
   output logic analog_input_cfg,
   output logic analog_pass,
   output logic ttl_level
);
   logic master_reg;
   logic slave_reg;
   logic in_reg;
   logic af_and;
   logic drive_val;
   gppc_pkg::gppc_cfg_t mode;

   assign mode = gppc_pkg::gppc_cfg_t'(cfg);

   // Sources that are not enabled read as one so they drop out of the AND
   always_comb begin
      af_and = 1'b1;
      for (int i = 0; i < AF_COUNT; i++) begin
         if (altfunc_output_cfg_en[i]) begin
            af_and = af_and & altfunc_output_cfg[i];
         end
      end
      if (ADC_BIT && mode == gppc_pkg::GPPC_AF_OD) begin
         af_and = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         master_reg <= 1'b1;
      end else if (wr_bit) begin
         master_reg <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         slave_reg <= 1'b1;
      end else if (mode == gppc_pkg::GPPC_AF_PP || mode == gppc_pkg::GPPC_AF_OD) begin
         slave_reg <= af_and;
      end else if (xfer_end) begin
         slave_reg <= master_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         in_reg <= 1'b1;
      end else if (mode == gppc_pkg::GPPC_OUT_PP || mode == gppc_pkg::GPPC_OUT_OD) begin
         if (xfer_end) begin
            in_reg <= master_reg;
         end
      end else if (sample_start) begin
         in_reg <= pin_in;
      end
   end

   assign drive_val = slave_reg;

   // Drive type follows cfg directly, so a config write is seen at once
   always_comb begin
      pin_out = 1'b0;
      pin_oe = 1'b0;
      weak_pullup_en = 1'b0;
      unique case (mode)
         gppc_pkg::GPPC_BID_WP: begin
            pin_oe = ~drive_val;
            weak_pullup_en = PULLUP_PRESENT & drive_val;
         end
         gppc_pkg::GPPC_BID_OD: begin
            pin_oe = ~drive_val;
         end
         gppc_pkg::GPPC_OUT_PP, gppc_pkg::GPPC_AF_PP: begin
            pin_oe = 1'b1;
            pin_out = drive_val;
         end
         gppc_pkg::GPPC_OUT_OD, gppc_pkg::GPPC_AF_OD: begin
            pin_oe = ~drive_val;
         end
         gppc_pkg::GPPC_IN_CMOS, gppc_pkg::GPPC_IN_TTL: begin
            pin_oe = 1'b0;
         end
      endcase
   end

   assign input_latch = in_reg;
   // Driven value is seen by the alternate inputs whenever the buffer drives
   assign analog_input_cfg = pin_oe ? pin_out : pin_in;
   assign analog_pass = ADC_BIT && mode == gppc_pkg::GPPC_AF_OD;
   assign ttl_level = (mode != gppc_pkg::GPPC_IN_CMOS);
endmodule

// ===== gppc_port.sv
// Eight-bit general purpose port with per-bit configuration
`timescale 1ns/100ps
`include "gppc_defs.svh"
// Functional notes
// - Output mode turns buffer on, open drain or push pull per config.
// - Output mode: instruction end copies master to slave and input latch.
// - Bidirectional drives open drain or weak pull-up unless pull-up absent.
// - Bidirectional and alt output sample pin at instruction start.
// - Bidirectional copies master to slave at instruction end.
// - Bidirectional reads return pin level, not output latch.
// - Alt output: function signal loads slave; none means high or high-Z.
// - Shared alternate outputs are ANDed before driving pin.
// - Input buffer feeds alternate inputs directly; port reads still work.
// - Analog bit in open-drain alt TTL forces output 1, passes voltage.
// - Driven output value always appears on alternate input path.
// - Wait and halt keep pins unchanged except alt output pins, which follow the function; clock outputs stop in halt.
// - Three config bits select input, output or bidirectional per pin.
// - Input mode: tristate, sample at start, master to slave at end.
// - Reset: weak pull-up bidirectional, data all ones; else high-Z.
// - Per-bit bits select modes and TTL or CMOS input level.
module gppc_port #(
   parameter int WIDTH = 8,
   parameter int AF_COUNT = 2,
   parameter logic [7:0] PULLUP_MASK = 8'hff,
   parameter logic [7:0] ADC_MASK = 8'h00
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic wait_mode,
   input wire logic halt_mode,
   input wire logic clk_out_src,
   output logic clk_out,
   input wire logic [WIDTH*AF_COUNT-1:0] altfunc_output_cfg,
   input wire logic [WIDTH*AF_COUNT-1:0] altfunc_output_cfg_en,
   output logic [WIDTH-1:0] analog_input_cfg,
   output logic [WIDTH-1:0] analog_pass,
   output logic [WIDTH-1:0] ttl_level,
   output logic [WIDTH-1:0] weak_pullup_en,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe
);
   logic [7:0] cfg_a_reg;
   logic [7:0] cfg_b_reg;
   logic [7:0] cfg_c_reg;
   logic [7:0] rdata_reg;
   logic [3:0] cyc_reg;
   logic clk_gate_reg;
   logic hold;
   logic sample_start;
   logic xfer_end;
   logic wr_data_hit;
   logic [WIDTH-1:0] in_latch;
   gppc_pkg::gppc_phase_t phase_reg;

   assign hold = wait_mode | halt_mode;
   assign wr_data_hit = reg_wr && reg_addr == `GPPC_OFF_DATA;

   // Instruction cycle sequencer: start, execute, end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cyc_reg <= 4'h0;
      end else if (!hold) begin
         cyc_reg <= (cyc_reg == `GPPC_INSTR_CYCLES - 4'h1) ? 4'h0 : cyc_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         phase_reg <= gppc_pkg::GPPC_ST_START;
      end else if (!hold) begin
         unique case (phase_reg)
            gppc_pkg::GPPC_ST_START: phase_reg <= gppc_pkg::GPPC_ST_EXEC;
            gppc_pkg::GPPC_ST_EXEC: begin
               if (cyc_reg == `GPPC_INSTR_CYCLES - 4'h2) begin
                  phase_reg <= gppc_pkg::GPPC_ST_END;
               end
            end
            gppc_pkg::GPPC_ST_END: phase_reg <= gppc_pkg::GPPC_ST_START;
            default: phase_reg <= gppc_pkg::GPPC_ST_START;
         endcase
      end
   end

   // Input latch and slave updates freeze in wait and halt so pins outside alt output modes keep their state
   assign sample_start = !hold && phase_reg == gppc_pkg::GPPC_ST_START;
   assign xfer_end = !hold && phase_reg == gppc_pkg::GPPC_ST_END;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg_a_reg <= `GPPC_RST_CFG_A;
         cfg_b_reg <= `GPPC_RST_CFG_B;
         cfg_c_reg <= `GPPC_RST_CFG_C | (`GPPC_RST_CFG_C_NOPU & ~PULLUP_MASK);
      end else if (reg_wr) begin
         if (reg_addr == `GPPC_OFF_CFG_A) begin
            cfg_a_reg <= reg_wdata;
         end
         if (reg_addr == `GPPC_OFF_CFG_B) begin
            cfg_b_reg <= reg_wdata;
         end
         if (reg_addr == `GPPC_OFF_CFG_C) begin
            cfg_c_reg <= reg_wdata;
         end
      end
   end

   for (genvar n = 0; n < WIDTH; n++) begin : g_bit
      gppc_bit #(
         .AF_COUNT(AF_COUNT),
         .PULLUP_PRESENT(PULLUP_MASK[n]),
         .ADC_BIT(ADC_MASK[n])
      ) u_bit (
         .clk_sys(clk_sys),
         .sys_rst(sys_rst),
         .cfg({cfg_c_reg[n], cfg_b_reg[n], cfg_a_reg[n]}),
         .sample_start(sample_start),
         .xfer_end(xfer_end),
         .wr_data(reg_wdata[n]),
         .wr_bit(wr_data_hit),
         .altfunc_output_cfg(altfunc_output_cfg[n*AF_COUNT +: AF_COUNT]),
         .altfunc_output_cfg_en(altfunc_output_cfg_en[n*AF_COUNT +: AF_COUNT]),
         .pin_in(pin_in[n]),
         .pin_out(pin_out[n]),
         .pin_oe(pin_oe[n]),
         .weak_pullup_en(weak_pullup_en[n]),
         .input_latch(in_latch[n]),
         .analog_input_cfg(analog_input_cfg[n]),
         .analog_pass(analog_pass[n]),
         .ttl_level(ttl_level[n])
      );
   end

   // Clock output runs in wait, stops in halt
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         clk_gate_reg <= 1'b0;
      end else begin
         clk_gate_reg <= clk_out_src & ~halt_mode;
      end
   end
   assign clk_out = clk_gate_reg;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `GPPC_OFF_DATA: rdata_reg <= 8'(in_latch);
            `GPPC_OFF_CFG_A: rdata_reg <= cfg_a_reg;
            `GPPC_OFF_CFG_B: rdata_reg <= cfg_b_reg;
            `GPPC_OFF_CFG_C: rdata_reg <= cfg_c_reg;
            `GPPC_OFF_STATUS: rdata_reg <= {6'h00, hold, phase_reg == gppc_pkg::GPPC_ST_END};
            `GPPC_OFF_PIN: rdata_reg <= 8'(pin_in);
            `GPPC_OFF_AFOUT: rdata_reg <= 8'(analog_input_cfg);
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign reg_rdata = rdata_reg;
endmodule

// ===== gppc_port_assertions.sv
// Concurrent checks on the port pins, clock output and read port
`timescale 1ns/100ps
module gppc_port_checker #(
   parameter int WIDTH = 8,
   parameter int AF_COUNT = 2,
   parameter logic [7:0] PULLUP_MASK = 8'hff,
   parameter logic [7:0] ADC_MASK = 8'h00
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic wait_mode,
   input wire logic halt_mode,
   input wire logic clk_out_src,
   input wire logic clk_out,
   input wire logic [WIDTH*AF_COUNT-1:0] altfunc_output_cfg,
   input wire logic [WIDTH*AF_COUNT-1:0] altfunc_output_cfg_en,
   input wire logic [WIDTH-1:0] analog_input_cfg,
   input wire logic [WIDTH-1:0] analog_pass,
   input wire logic [WIDTH-1:0] ttl_level,
   input wire logic [WIDTH-1:0] weak_pullup_en,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_af_loop; analog_input_cfg == ((pin_out & pin_oe) | (pin_in & ~pin_oe)); endproperty
   a_af_loop: assert property (p_af_loop) else $error("alt input path wrong");
   property p_halt_clk; $past(halt_mode) |-> clk_out == 1'b0; endproperty
   a_halt_clk: assert property (p_halt_clk) else $error("clock out runs in halt");
   property p_clk_fwd;
      !$past(sys_rst) && !$past(halt_mode) && !halt_mode |-> clk_out == $past(clk_out_src);
   endproperty
   a_clk_fwd: assert property (p_clk_fwd) else $error("clock out not forwarded");
   property p_hold;
      (wait_mode || halt_mode) && $past(wait_mode || halt_mode) && !$past(reg_wr)
         && !$past(sys_rst) && $stable(altfunc_output_cfg) && $stable(altfunc_output_cfg_en)
         && $past(altfunc_output_cfg) == $past(altfunc_output_cfg, 2) && $past(altfunc_output_cfg_en) == $past(altfunc_output_cfg_en, 2)
         |-> $stable(pin_out) && $stable(pin_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("pins moved while frozen");
   property p_wp_low; (weak_pullup_en & pin_oe) == '0; endproperty
   a_wp_low: assert property (p_wp_low) else $error("pull-up bit drives high");
   property p_adc_hiz; (analog_pass & pin_oe) == '0; endproperty
   a_adc_hiz: assert property (p_adc_hiz) else $error("analog bit driven");
   property p_masks;
      (analog_pass & ~ADC_MASK[WIDTH-1:0]) == '0
         && (weak_pullup_en & ~PULLUP_MASK[WIDTH-1:0]) == '0;
   endproperty
   a_masks: assert property (p_masks) else $error("mask ignored");
   property p_ttl; ((analog_pass | weak_pullup_en) & ~ttl_level) == '0; endproperty
   a_ttl: assert property (p_ttl) else $error("input level wrong");
   property p_rst;
      disable iff (1'b0) sys_rst ##1 sys_rst
         |-> pin_oe == '0 && weak_pullup_en == PULLUP_MASK[WIDTH-1:0];
   endproperty
   a_rst: assert property (p_rst) else $error("reset pin state wrong");
   c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
   c_wait: cover property (wait_mode [*8]);
   c_adc: cover property (analog_pass != '0);
endmodule
bind gppc_port gppc_port_checker #(.WIDTH(WIDTH), .AF_COUNT(AF_COUNT),
   .PULLUP_MASK(PULLUP_MASK), .ADC_MASK(ADC_MASK)) chk_u (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .wait_mode(wait_mode), .halt_mode(halt_mode), .clk_out_src(clk_out_src),
   .clk_out(clk_out), .altfunc_output_cfg(altfunc_output_cfg), .altfunc_output_cfg_en(altfunc_output_cfg_en), .analog_input_cfg(analog_input_cfg),
   .analog_pass(analog_pass), .ttl_level(ttl_level), .weak_pullup_en(weak_pullup_en),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== gppc_pad_model.sv
// Pads: port drive, outside drivers, pull-ups; a floating pad toggles
`timescale 1ns/100ps
module gppc_pad_model (
   input wire logic clk_sys,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] weak_pullup_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_in
);
   logic [7:0] last_reg = 8'hff;
   always_ff @(posedge clk_sys) last_reg <= pin_in;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i] && ext_en[i])
            pin_in[i] = pin_out[i] & ext_val[i];
         else if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (weak_pullup_en[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = ~last_reg[i];
      end
   end
endmodule

// ===== gppc_port_bench.sv
// Self-checking bench for the eight-bit port
`timescale 1ns/100ps
module gppc_port_bench;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic wait_mode = 1'b0;
   logic halt_mode = 1'b0;
   logic clk_out_src = 1'b0;
   logic [15:0] altfunc_output_cfg = 16'h0000;
   logic [15:0] altfunc_output_cfg_en = 16'h0000;
   logic [7:0] ext_en = 8'h80;
   logic [7:0] ext_val = 8'h80;
   logic [7:0] reg_rdata, analog_input_cfg, analog_pass, ttl_level, weak_pullup_en, pin_in, pin_out, pin_oe;
   logic clk_out;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) clk_out_src <= ~clk_out_src;
   gppc_port #(.PULLUP_MASK(8'h7f), .ADC_MASK(8'h80)) dut_u (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_mode(wait_mode), .halt_mode(halt_mode),
      .clk_out_src(clk_out_src), .clk_out(clk_out), .altfunc_output_cfg(altfunc_output_cfg), .altfunc_output_cfg_en(altfunc_output_cfg_en),
      .analog_input_cfg(analog_input_cfg), .analog_pass(analog_pass), .ttl_level(ttl_level),
      .weak_pullup_en(weak_pullup_en), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   gppc_pad_model pad_u (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
      .weak_pullup_en(weak_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk("read data", exp, reg_rdata);
   endtask
   // Two whole instructions, so every start and end phase has passed
   task automatic settle();
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      chk("oe", 8'h00, pin_oe);
      chk("pullup", 8'h7f, weak_pullup_en);
      // Freeze the sequencer in its end phase, then read the status register
      repeat (3) @(posedge clk_sys);
      wait_mode <= 1'b1;
      rd(4'h4, 8'h03);
      @(posedge clk_sys);
      wait_mode <= 1'b0;
      rd(4'h0, 8'hff);
      rd(4'h3, 8'h80);
      rd(4'h9, 8'h00);
      @(posedge clk_sys);
      ext_en <= 8'hff;
      ext_val <= 8'h00;
      wr(4'h2, 8'hff);
      wr(4'h0, 8'h5a);
      settle();
      chk("out", 8'h5a, pin_out);
      chk("oe", 8'hff, pin_oe);
      rd(4'h0, 8'h5a);
      wr(4'h3, 8'hff);
      chk("oe", 8'ha5, pin_oe);
      wr(4'h2, 8'h00);
      @(posedge clk_sys);
      ext_val <= 8'hf3;
      wr(4'h0, 8'h0f);
      settle();
      rd(4'h0, 8'h03);
      wr(4'h0, 8'h83);
      settle();
      rd(4'h0, 8'h83);
      chk("oe", 8'h7c, pin_oe);
      @(posedge clk_sys);
      ext_en <= 8'h80;
      ext_val <= 8'h80;
      wr(4'h3, 8'h00);
      wr(4'h0, 8'hff);
      settle();
      chk("oe", 8'h00, pin_oe);
      rd(4'h0, 8'hff);
      wr(4'h1, 8'hff);
      chk("ttl", 8'h00, ttl_level);
      @(posedge clk_sys);
      ext_en <= 8'hff;
      ext_val <= 8'h3c;
      settle();
      rd(4'h0, 8'h3c);
      rd(4'h5, 8'h3c);
      chk("alt in", 8'h3c, analog_input_cfg);
      wr(4'h0, 8'h99);
      settle();
      chk("oe", 8'h00, pin_oe);
      wr(4'h1, 8'h00);
      wr(4'h2, 8'hff);
      settle();
      chk("out", 8'h99, pin_out);
      @(posedge clk_sys);
      wait_mode <= 1'b1;
      wr(4'h0, 8'h66);
      settle();
      chk("out", 8'h99, pin_out);
      @(posedge clk_sys);
      wait_mode <= 1'b0;
      settle();
      chk("out", 8'h66, pin_out);
      @(posedge clk_sys);
      halt_mode <= 1'b1;
      settle();
      chk("clk out", 8'h00, {7'h00, clk_out});
      @(posedge clk_sys);
      halt_mode <= 1'b0;
      wr(4'h1, 8'hff);
      @(posedge clk_sys);
      altfunc_output_cfg_en <= 16'hffff;
      altfunc_output_cfg <= 16'hfffe;
      settle();
      chk("out", 8'hfe, pin_out);
      @(posedge clk_sys);
      altfunc_output_cfg_en <= 16'h0000;
      settle();
      chk("out", 8'hff, pin_out);
      rd(4'h0, 8'h3c);
      rd(4'h6, 8'hff);
      wr(4'h3, 8'hff);
      settle();
      chk("oe", 8'h00, pin_oe);
      chk("analog", 8'h80, analog_pass);
      @(posedge clk_sys);
      altfunc_output_cfg_en <= 16'hffff;
      altfunc_output_cfg <= 16'h0000;
      settle();
      chk("oe", 8'h7f, pin_oe);
      tally_and_finish();
   end
endmodule
